// ---- src/swd_pkg.sv ----
// Package for the single-wire debug port control block
package swd_pkg;
  // Register offsets
  localparam logic [3:0] SWD_OFS_REV = 4'h0;
  localparam logic [3:0] SWD_OFS_ERR = 4'h1;
  localparam logic [3:0] SWD_OFS_FRAME = 4'h2;
  localparam logic [3:0] SWD_OFS_DIS = 4'h3;
  localparam logic [3:0] SWD_OFS_KEY = 4'h7;
  localparam logic [3:0] SWD_OFS_RST = 4'h8;
  localparam logic [3:0] SWD_OFS_CLKSEL = 4'h9;
  localparam logic [3:0] SWD_OFS_SYSCTL = 4'ha;
  localparam logic [3:0] SWD_OFS_SYSSTAT = 4'hb;
  localparam logic [3:0] SWD_OFS_CRC = 4'hc;
  // Field positions
  localparam int SWD_BIT_GAP = 7;
  localparam int SWD_BIT_PAR = 5;
  localparam int SWD_BIT_TMO = 4;
  localparam int SWD_BIT_RSP = 3;
  localparam int SWD_BIT_NACK = 4;
  localparam int SWD_BIT_CC = 3;
  localparam int SWD_BIT_PDIS = 2;
  localparam int SWD_BIT_UROW = 5;
  localparam int SWD_BIT_NVMK = 4;
  localparam int SWD_BIT_ERASE = 3;
  localparam int SWD_BIT_SYSTEM_CLOCK_REQUEST = 0;
  localparam int SWD_BIT_UROWFIN = 1;
  localparam int SWD_BIT_RSTSYS = 5;
  localparam int SWD_BIT_ASLEEP = 4;
  // Reset values and codes
  localparam logic [3:0] SWD_REVISION = 4'h2; // Arbitrary revision value
  localparam logic [7:0] SWD_RST_SIG = 8'h59;
  localparam logic [7:0] SWD_RST_RUN = 8'h00;
  localparam logic [1:0] SWD_CLKSEL_RST = 2'h3;
  localparam logic [7:0] SWD_FRAME_MASK = 8'hbf;
  localparam logic [7:0] SWD_DIS_MASK = 8'h1c;
  // Error signatures
  typedef enum logic [2:0] {
    SWD_ERR_NONE = 3'b000,
    SWD_ERR_PARITY = 3'b001,
    SWD_ERR_FRAME = 3'b010,
    SWD_ERR_TIMEOUT = 3'b011,
    SWD_ERR_START = 3'b100,
    SWD_ERR_BUS = 3'b110,
    SWD_ERR_CONTEND = 3'b111
  } swd_err_e;
  // Timing
  localparam int SWD_TMO_CYCLES = 65536;
  localparam int SWD_GAP_BITS = 2;
  localparam logic [7:0] SWD_GUARD_MAX = 8'h80;
endpackage : swd_pkg

// ---- src/swd_buf_if.sv ----
// Interface carrying transmit bytes between the control block and its buffer
`timescale 1ns/1ps
interface swd_buf_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : swd_buf_if

// ---- src/swd_skid_buf.sv ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module swd_skid_buf (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Filling side
  swd_buf_if.dst in_side,
  // Draining side
  output logic o_valid,
  output logic [7:0] o_data,
  input wire logic i_ready
);
  logic [7:0] mem [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire push = in_side.valid && in_side.ready;
  wire pop = o_valid && i_ready;
  // Handshakes from the fill count
  assign in_side.ready = (count != 2'd2);
  assign o_valid = (count != 2'd0);
  assign o_data = mem[rd_ptr];
  // Pointers and count
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
  // Storage has no reset
  always_ff @(posedge i_mclk) begin
    if (push) mem[wr_ptr] <= in_side.data;
  end
endmodule : swd_skid_buf

// ---- src/swd_ctrl.sv ----
// Control and status registers of the single-wire debug port
`timescale 1ns/1ps
//
// Contract
// [RULE1] Link side keeps running in every sleep state.
// [RULE2] System bus accesses blocked while the system clock is stopped.
// [RULE3] System asleep flag readable in system state register.
// [RULE4] Clock request keeps system clock on through sleep, bus stays reachable.
// [RULE5] Clock request bit set to one whenever the port becomes enabled.
// [RULE6] These registers are reachable only through the debugger instructions.
// [RULE7] Upper nibble of revision register holds a fixed revision.
// [RULE8] Error signature loads on error, clears when the debugger reads it.
// [RULE9] Signature codes: parity 1, frame 2, timeout 3, start 4, bus 6, contention 7.
// [RULE10] Gap enable inserts two idle bits between transmitted load bytes.
// [RULE11] Parity disable ignores parity and never flags parity errors.
// [RULE12] Timeout flagged after 65536 cycles with no response unless disabled.
// [RULE13] Response signature disable suppresses all response signatures.
// [RULE14] Guard time 128 down to 2 cycles for codes 0..6, 7 reserved.
// [RULE15] Negative ack off suppresses NACK on system reset mid load/store.
// [RULE16] Contention detection runs while its disable bit is zero.
// [RULE17] Port disable turns off link, drops clock request, clears config and keys.
// [RULE18] Erase key flag set on decode, cleared by the erase reset request.
// [RULE19] 0x59 asserts system reset, 0x00 releases, port itself not reset.
// [RULE20] Clock request cleared whenever the port is disabled.
module swd_ctrl
  import swd_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Register access from the link instruction decoder
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Events from the link layer
  input wire logic i_rx_parity_bad,
  input wire logic i_rx_stop_bad,
  input wire logic i_rx_start_bad,
  input wire logic i_bus_error,
  input wire logic i_contention,
  input wire logic i_acc_request,
  input wire logic i_acc_response,
  input wire logic i_turnaround,
  input wire logic i_multi_load,
  input wire logic i_ldst_active,
  // Key decoder
  input wire logic i_key_erase,
  input wire logic i_key_nvm,
  input wire logic i_key_urow,
  input wire logic i_nvm_session_start,
  // System side pins
  input wire logic i_sys_asleep_pin,
  input wire logic i_sys_clk_running_pin,
  input wire logic i_sys_in_reset_pin,
  input wire logic i_nvm_prog_pin,
  input wire logic i_urow_prog_pin,
  input wire logic i_locked_pin,
  input wire logic [2:0] i_crc_status_pin,
  input wire logic i_enable_pin,
  // Transmit byte stream
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_take,
  // Controls to link and system
  output logic o_link_enable,
  output logic o_sys_clock_request,
  output logic o_sys_bus_allowed,
  output logic o_sys_reset,
  output logic o_tx_hold,
  output logic o_parity_check_on,
  output logic o_contention_check_on,
  output logic o_rsp_sig_enable,
  output logic o_nack_send,
  output logic o_timeout,
  output logic [1:0] o_clock_select,
  output logic o_urow_final
);
  // Synchronisers for system pins
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic [2:0] crc1;
  logic [2:0] crc2;
  // Registers
  logic [2:0] err_sig;
  logic [7:0] frame_ctl;
  logic [7:0] dis_ctl;
  logic key_erase_f;
  logic key_nvm_f;
  logic key_urow_f;
  logic [7:0] rst_req;
  logic [1:0] clk_sel;
  logic clk_req;
  logic urow_fin;
  logic rst_seen;
  logic enabled;
  logic en_pin_q;
  logic [16:0] tmo_cnt;
  logic [7:0] guard_cnt;
  logic [1:0] gap_cnt;
  logic [7:0] rdata;

  // Pin inputs pass two flip-flops
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
      crc1 <= 3'h0;
      crc2 <= 3'h0;
      en_pin_q <= 1'b0;
    end else begin
      sync1 <= {i_enable_pin, i_locked_pin, i_urow_prog_pin, i_nvm_prog_pin, i_sys_in_reset_pin,
                i_sys_clk_running_pin, i_sys_asleep_pin, 2'b00};
      sync2 <= sync1;
      crc1 <= i_crc_status_pin;
      crc2 <= crc1;
      en_pin_q <= sync2[8];
    end
  end
  wire sys_asleep = sync2[2];
  wire sys_clk_run = sync2[3];
  wire sys_in_rst = sync2[4];
  wire nvm_prog = sync2[5];
  wire urow_prog = sync2[6];
  wire locked = sync2[7];
  wire en_pin = sync2[8];

  // Register decode
  wire wr_err = i_reg_wr && (i_reg_addr == SWD_OFS_ERR);
  wire rd_err = i_reg_rd && (i_reg_addr == SWD_OFS_ERR);
  wire wr_frame = i_reg_wr && (i_reg_addr == SWD_OFS_FRAME);
  wire wr_dis = i_reg_wr && (i_reg_addr == SWD_OFS_DIS);
  wire wr_key = i_reg_wr && (i_reg_addr == SWD_OFS_KEY);
  wire wr_rst = i_reg_wr && (i_reg_addr == SWD_OFS_RST);
  wire wr_clksel = i_reg_wr && (i_reg_addr == SWD_OFS_CLKSEL);
  wire wr_sysctl = i_reg_wr && (i_reg_addr == SWD_OFS_SYSCTL);
  wire rd_sysstat = i_reg_rd && (i_reg_addr == SWD_OFS_SYSSTAT);
  wire disable_req = wr_dis && i_reg_wdata[SWD_BIT_PDIS];
  // Only a rising enable level enables, so a disable write is not undone at once
  wire enable_rise = en_pin && !en_pin_q;
  wire sig_reset = (rst_req == SWD_RST_SIG);

  // Control bits seen by the link
  wire gap_on = frame_ctl[SWD_BIT_GAP];
  wire par_off = frame_ctl[SWD_BIT_PAR];
  wire tmo_off = frame_ctl[SWD_BIT_TMO];
  wire rsp_off = frame_ctl[SWD_BIT_RSP];
  wire [2:0] guard_sel = frame_ctl[2:0];
  wire nack_off = dis_ctl[SWD_BIT_NACK];
  wire cc_off = dis_ctl[SWD_BIT_CC];

  // Error detection with priority toward the most severe code
  wire tmo_hit = !tmo_off && (tmo_cnt == 17'(SWD_TMO_CYCLES)); // [RULE12]
  wire par_hit = i_rx_parity_bad && !par_off; // [RULE11]
  wire cc_hit = i_contention && !cc_off; // [RULE16]
  swd_err_e next_err;
  assign next_err = cc_hit ? SWD_ERR_CONTEND : // [RULE9]
                    i_bus_error ? SWD_ERR_BUS :
                    i_rx_start_bad ? SWD_ERR_START :
                    tmo_hit ? SWD_ERR_TIMEOUT :
                    i_rx_stop_bad ? SWD_ERR_FRAME :
                    par_hit ? SWD_ERR_PARITY : SWD_ERR_NONE;

  // Guard length from the select code; code 7 falls back to the default
  wire [7:0] guard_len = (guard_sel == 3'h7) ? SWD_GUARD_MAX :
                         (SWD_GUARD_MAX >> guard_sel); // [RULE14]

  // Enable, reset request and clock request
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      enabled <= 1'b0;
      rst_req <= 8'h00;
      clk_req <= 1'b0;
      clk_sel <= SWD_CLKSEL_RST;
      urow_fin <= 1'b0;
      rst_seen <= 1'b0;
    end else if (disable_req) begin
      enabled <= 1'b0; // [RULE17]
      rst_req <= 8'h00;
      clk_req <= 1'b0; // [RULE20]
      clk_sel <= SWD_CLKSEL_RST;
      urow_fin <= 1'b0;
      rst_seen <= 1'b0;
    end else begin
      if (enable_rise) enabled <= 1'b1;
      if (wr_rst) rst_req <= i_reg_wdata; // [RULE19]
      if (enable_rise) clk_req <= 1'b1; // [RULE5]
      else if (wr_sysctl) clk_req <= i_reg_wdata[SWD_BIT_SYSTEM_CLOCK_REQUEST];
      if (enable_rise) clk_sel <= SWD_CLKSEL_RST;
      else if (wr_clksel) clk_sel <= i_reg_wdata[1:0];
      urow_fin <= wr_sysctl && i_reg_wdata[SWD_BIT_UROWFIN] && key_urow_f;
      if (sys_in_rst || sig_reset) rst_seen <= 1'b1;
      else if (rd_sysstat) rst_seen <= 1'b0;
    end
  end

  // Configuration registers, error signature and key flags
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      frame_ctl <= 8'h00;
      dis_ctl <= 8'h00;
      err_sig <= 3'h0;
      key_erase_f <= 1'b0;
      key_nvm_f <= 1'b0;
      key_urow_f <= 1'b0;
    end else if (disable_req) begin
      frame_ctl <= 8'h00; // [RULE17]
      dis_ctl <= 8'h00;
      err_sig <= 3'h0;
      key_erase_f <= 1'b0;
      key_nvm_f <= 1'b0;
      key_urow_f <= 1'b0;
    end else begin
      if (wr_frame) frame_ctl <= i_reg_wdata & SWD_FRAME_MASK;
      if (wr_dis) dis_ctl <= i_reg_wdata & SWD_DIS_MASK;
      // A new error wins over the clear on read
      if (next_err != SWD_ERR_NONE) err_sig <= next_err; // [RULE8]
      else if (rd_err) err_sig <= 3'h0;
      if (i_key_erase) key_erase_f <= 1'b1; // [RULE18]
      else if (sig_reset) key_erase_f <= 1'b0;
      if (i_key_nvm) key_nvm_f <= 1'b1;
      else if (i_nvm_session_start) key_nvm_f <= 1'b0;
      if (i_key_urow) key_urow_f <= 1'b1;
      else if (wr_key && i_reg_wdata[SWD_BIT_UROW]) key_urow_f <= 1'b0;
    end
  end

  // Access-layer response timeout counter, link clock keeps counting in sleep
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      tmo_cnt <= 17'd0;
    end else if (i_acc_response || !enabled || tmo_hit) begin
      tmo_cnt <= 17'd0;
    end else if (i_acc_request || (tmo_cnt != 17'd0)) begin
      tmo_cnt <= tmo_cnt + 17'd1; // [RULE12]
    end
  end

  // Guard and inter-byte gap timers hold the transmitter
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      guard_cnt <= 8'h00;
      gap_cnt <= 2'd0;
    end else begin
      if (i_turnaround) guard_cnt <= guard_len; // [RULE14]
      else if (guard_cnt != 8'h00) guard_cnt <= guard_cnt - 8'h01;
      if (o_tx_valid && i_tx_take && gap_on && i_multi_load) begin
        gap_cnt <= 2'(SWD_GAP_BITS); // [RULE10]
      end else if (gap_cnt != 2'd0) begin
        gap_cnt <= gap_cnt - 2'd1;
      end
    end
  end

  // Transmit path through the two-entry buffer
  swd_buf_if tx_bus ();
  assign tx_bus.valid = i_tx_valid && enabled;
  assign tx_bus.data = i_tx_data;
  assign o_tx_ready = tx_bus.ready && enabled;
  wire buf_valid;
  wire [7:0] buf_data;
  wire tx_stall = (guard_cnt != 8'h00) || (gap_cnt != 2'd0);
  swd_skid_buf u_txbuf (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .in_side(tx_bus),
    .o_valid(buf_valid),
    .o_data(buf_data),
    .i_ready(i_tx_take && !tx_stall)
  );
  assign o_tx_valid = buf_valid && !tx_stall;
  assign o_tx_data = buf_data;
  assign o_tx_hold = tx_stall;

  // Outputs to link and system
  assign o_link_enable = enabled; // [RULE1]
  assign o_sys_clock_request = clk_req && enabled; // [RULE4]
  assign o_sys_bus_allowed = enabled && (sys_clk_run || clk_req); // [RULE2]
  assign o_sys_reset = sig_reset; // [RULE19]
  assign o_parity_check_on = !par_off;
  assign o_contention_check_on = !cc_off;
  assign o_rsp_sig_enable = !rsp_off; // [RULE13]
  assign o_nack_send = !nack_off && sig_reset && i_ldst_active; // [RULE15]
  assign o_timeout = tmo_hit;
  assign o_clock_select = clk_sel;
  assign o_urow_final = urow_fin;

  // Read data mux, only reached through the link instruction decoder
  always_comb begin
    rdata = 8'h00; // [RULE6]
    if (i_reg_addr == SWD_OFS_REV) begin
      rdata = {SWD_REVISION, 4'h0}; // [RULE7]
    end else if (i_reg_addr == SWD_OFS_ERR) begin
      rdata = {5'h00, err_sig};
    end else if (i_reg_addr == SWD_OFS_FRAME) begin
      rdata = frame_ctl;
    end else if (i_reg_addr == SWD_OFS_DIS) begin
      rdata = dis_ctl;
    end else if (i_reg_addr == SWD_OFS_KEY) begin
      rdata = {2'b00, key_urow_f, key_nvm_f, key_erase_f, 3'b000};
    end else if (i_reg_addr == SWD_OFS_RST) begin
      rdata = rst_req;
    end else if (i_reg_addr == SWD_OFS_CLKSEL) begin
      rdata = {6'h00, clk_sel};
    end else if (i_reg_addr == SWD_OFS_SYSCTL) begin
      rdata = {6'h00, urow_fin, clk_req};
    end else if (i_reg_addr == SWD_OFS_SYSSTAT) begin
      rdata = {2'b00, rst_seen, sys_asleep, nvm_prog, urow_prog, 1'b0, locked}; // [RULE3]
    end else if (i_reg_addr == SWD_OFS_CRC) begin
      rdata = {5'h00, crc2};
    end
  end

  // Registered read data
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) o_reg_rdata <= 8'h00;
    else if (i_reg_rd) o_reg_rdata <= rdata;
  end
endmodule : swd_ctrl

// ---- test/swd_ctrl_sva.sv ----
// Checker of the debug port control block, bound to its ports
`timescale 1ns/1ps
module swd_ctrl_sva
  import swd_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Register access
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // Link events and pins
  input wire logic i_rx_parity_bad,
  input wire logic i_rx_stop_bad,
  input wire logic i_rx_start_bad,
  input wire logic i_bus_error,
  input wire logic i_contention,
  input wire logic i_turnaround,
  input wire logic i_sys_clk_running_pin,
  // Controls
  input wire logic o_link_enable,
  input wire logic o_sys_clock_request,
  input wire logic o_sys_bus_allowed,
  input wire logic o_sys_reset,
  input wire logic o_tx_valid,
  input wire logic o_parity_check_on,
  input wire logic o_rsp_sig_enable,
  input wire logic o_timeout
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  logic others;
  logic quiet;
  logic rd_err;
  // Cycles without any error source, and reads of the error register
  assign others = i_rx_stop_bad | i_rx_start_bad | i_bus_error | i_contention | o_timeout;
  assign quiet = !(others | i_rx_parity_bad);
  assign rd_err = i_reg_rd && i_reg_addr == SWD_OFS_ERR;
  AST_REV: assert property (i_reg_rd && i_reg_addr == SWD_OFS_REV |=> o_reg_rdata[7:4] == SWD_REVISION)
    else $error("revision field wrong");
  AST_ERR_CLEAR: assert property (rd_err && quiet ##1 quiet ##1 rd_err && quiet |=> o_reg_rdata == 8'h00)
    else $error("error signature not cleared by read");
  AST_SIG_PARITY: assert property (i_rx_parity_bad && !others && o_parity_check_on ##1 quiet && !rd_err ##1 rd_err && quiet |=> o_reg_rdata[2:0] == 3'h1)
    else $error("parity signature wrong");
  AST_PAR_CFG: assert property (i_reg_wr && i_reg_addr == SWD_OFS_FRAME && o_link_enable |=> o_parity_check_on == !$past(i_reg_wdata[5]))
    else $error("parity check control wrong");
  AST_RSP_CFG: assert property (i_reg_wr && i_reg_addr == SWD_OFS_FRAME && o_link_enable |=> o_rsp_sig_enable == !$past(i_reg_wdata[3]))
    else $error("response signature control wrong");
  AST_GUARD: assert property (i_turnaround |=> !o_tx_valid [*2])
    else $error("byte offered inside guard time");
  AST_BUS: assert property (!i_sys_clk_running_pin [*3] ##0 !o_sys_clock_request |-> !o_sys_bus_allowed)
    else $error("bus allowed with system clock stopped");
  AST_SYSTEM_CLOCK_REQUEST_ON: assert property ($rose(o_link_enable) |-> o_sys_clock_request)
    else $error("clock request not set on enable");
  AST_SYSTEM_CLOCK_REQUEST_OFF: assert property (!o_link_enable |-> !o_sys_clock_request)
    else $error("clock request while disabled");
  AST_SYSRST: assert property (i_reg_wr && i_reg_addr == SWD_OFS_RST && i_reg_wdata == 8'h59 |=> o_sys_reset && o_link_enable == $past(o_link_enable))
    else $error("system reset request mishandled");
  AST_DIS: assert property (i_reg_wr && i_reg_addr == SWD_OFS_DIS && i_reg_wdata[2] |=> !o_link_enable && !o_sys_clock_request && o_parity_check_on && o_rsp_sig_enable)
    else $error("port disable incomplete");
endmodule : swd_ctrl_sva

bind swd_ctrl swd_ctrl_sva chk (.i_mclk, .i_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr,
  .i_reg_wdata, .o_reg_rdata, .i_rx_parity_bad, .i_rx_stop_bad, .i_rx_start_bad, .i_bus_error,
  .i_contention, .i_turnaround, .i_sys_clk_running_pin, .o_link_enable, .o_sys_clock_request,
  .o_sys_bus_allowed, .o_sys_reset, .o_tx_valid, .o_parity_check_on, .o_rsp_sig_enable,
  .o_timeout);

// ---- test/swd_link_sink.sv ----
// Model of the debugger taking transmitted bytes, able to stall
`timescale 1ns/1ps
module swd_link_sink (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Byte stream from the port
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  input wire logic i_stall,
  output logic o_take
);
  logic [7:0] got[$];
  int at[$];
  int cyc;
  // Take whatever is offered unless stalled
  assign o_take = i_valid && !i_stall;
  // Record each byte with the cycle it was taken in
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
      if (o_take) begin
        got.push_back(i_data);
        at.push_back(cyc);
      end
    end
  end
endmodule : swd_link_sink

// ---- test/tb.sv ----
// Self-checking bench of the debug port control block
`timescale 1ns/1ps
module tb;
  import swd_pkg::*;
  logic i_mclk = '0, i_reset = '1, i_reg_wr = '0, i_reg_rd = '0, stall = '1;
  logic [3:0] i_reg_addr = '0;
  logic [7:0] i_reg_wdata = '0, o_reg_rdata, i_tx_data = '0, o_tx_data, rv;
  logic [4:0] errv = '0;
  logic i_rx_parity_bad, i_rx_stop_bad, i_rx_start_bad, i_bus_error, i_contention;
  logic i_acc_request = '0, i_acc_response = '0, i_turnaround = '0, i_multi_load = '0;
  logic i_ldst_active = '0, i_key_erase = '0, i_key_nvm = '0, i_key_urow = '0;
  logic i_nvm_session_start = '0, i_sys_asleep_pin = '0, i_sys_clk_running_pin = '1;
  logic i_sys_in_reset_pin = '0, i_nvm_prog_pin = '0, i_urow_prog_pin = '0, i_locked_pin = '0;
  logic [2:0] i_crc_status_pin = '0;
  logic i_enable_pin = '0, i_tx_valid = '0, o_tx_ready, o_tx_valid, i_tx_take;
  logic o_link_enable, o_sys_clock_request, o_sys_bus_allowed, o_sys_reset, o_tx_hold;
  logic o_parity_check_on, o_contention_check_on, o_rsp_sig_enable, o_nack_send, o_timeout;
  logic [1:0] o_clock_select;
  logic o_urow_final;
  int fails = 0, checks_done = 0, n;
  // Rows: offset, written value, value read back
  logic [19:0] rows [8] = '{{SWD_OFS_FRAME, 8'hff, 8'hbf}, {SWD_OFS_DIS, 8'h18, 8'h18},
    {SWD_OFS_REV, 8'hff, 8'h20}, {4'h5, 8'hff, 8'h00}, {SWD_OFS_CLKSEL, 8'h02, 8'h02},
    {SWD_OFS_SYSCTL, 8'h01, 8'h01}, {SWD_OFS_DIS, 8'h00, 8'h00}, {SWD_OFS_FRAME, 8'h00, 8'h00}};
  logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
  logic [7:0] order [4] = '{8'ha0, 8'hb0, 8'ha1, 8'hb1};
  assign {i_contention, i_bus_error, i_rx_start_bad, i_rx_stop_bad, i_rx_parity_bad} = errv;
  // Clock
  always #2 i_mclk = ~i_mclk;
  swd_ctrl uut (.i_mclk, .i_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .i_rx_parity_bad, .i_rx_stop_bad, .i_rx_start_bad, .i_bus_error, .i_contention,
    .i_acc_request, .i_acc_response, .i_turnaround, .i_multi_load, .i_ldst_active, .i_key_erase,
    .i_key_nvm, .i_key_urow, .i_nvm_session_start, .i_sys_asleep_pin, .i_sys_clk_running_pin,
    .i_sys_in_reset_pin, .i_nvm_prog_pin, .i_urow_prog_pin, .i_locked_pin, .i_crc_status_pin,
    .i_enable_pin, .i_tx_valid, .i_tx_data, .o_tx_ready, .o_tx_valid, .o_tx_data, .i_tx_take,
    .o_link_enable, .o_sys_clock_request, .o_sys_bus_allowed, .o_sys_reset, .o_tx_hold,
    .o_parity_check_on, .o_contention_check_on, .o_rsp_sig_enable, .o_nack_send, .o_timeout,
    .o_clock_select, .o_urow_final);
  swd_link_sink sink (.i_mclk, .i_reset, .i_valid(o_tx_valid), .i_data(o_tx_data),
    .i_stall(stall), .o_take(i_tx_take));
  // Compare and count
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Register write, then let the edge settle
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_wr <= '1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_mclk);
    i_reg_wr <= '0;
    @(negedge i_mclk);
  endtask : wr
  // Register read into rv
  task rd(input logic [3:0] a);
    @(posedge i_mclk);
    i_reg_rd <= '1;
    i_reg_addr <= a;
    @(posedge i_mclk);
    i_reg_rd <= '0;
    @(negedge i_mclk);
    rv = o_reg_rdata;
  endtask : rd
  // One-cycle error pulse
  task err(input logic [4:0] v);
    @(posedge i_mclk);
    errv <= v;
    @(posedge i_mclk);
    errv <= '0;
  endtask : err
  // Offer one byte until the buffer takes it
  task push(input logic [7:0] d);
    @(posedge i_mclk);
    i_tx_valid <= '1;
    i_tx_data <= d;
    repeat (20) begin
      @(posedge i_mclk);
      if (o_tx_ready === 1'b1) break;
    end
    i_tx_valid <= '0;
  endtask : push
  // Verdict
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  // Watchdog against a hang
  initial begin
    #400000;
    fails++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge i_mclk);
    i_reset <= '0;
    i_enable_pin <= '1;
    n = 0;
    while (o_link_enable !== 1'b1 && n < 20) begin
      @(posedge i_mclk);
      n++;
    end
    @(negedge i_mclk);
    chk(8'(o_sys_clock_request), 8'h01);
    chk({5'h00, o_rsp_sig_enable, o_parity_check_on, o_contention_check_on}, 8'h07);
    rd(SWD_OFS_CLKSEL);
    chk(rv, 8'h03);
    rd(SWD_OFS_KEY);
    chk(rv, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16]);
      chk(rv, rows[i][7:0]);
    end
    // Every error code except timeout, then cleared by the read
    for (int k = 0; k < 5; k++) begin
      err(5'(5'h01 << k));
      rd(SWD_OFS_ERR);
      chk(rv, {5'h00, codes[k]});
      rd(SWD_OFS_ERR);
      chk(rv, 8'h00);
    end
    // Parity and contention checks switched off
    wr(SWD_OFS_FRAME, 8'h20);
    err(5'h01);
    wr(SWD_OFS_DIS, 8'h08);
    err(5'h10);
    rd(SWD_OFS_ERR);
    chk(rv, 8'h00);
    chk({6'h00, o_parity_check_on, o_contention_check_on}, 8'h00);
    wr(SWD_OFS_DIS, 8'h00);
    // Guard time for every code, with a byte waiting
    for (int c = 0; c < 8; c++) begin
      wr(SWD_OFS_FRAME, 8'(c));
      push(8'(c));
      @(posedge i_mclk);
      i_turnaround <= '1;
      @(posedge i_mclk);
      i_turnaround <= '0;
      n = 0;
      @(negedge i_mclk);
      while (o_tx_valid !== 1'b1 && n < 200) begin
        @(negedge i_mclk);
        n++;
      end
      chk(8'(n), 8'((c == 7) ? 128 : 128 >> c));
      @(posedge i_mclk);
      stall <= '0;
      repeat (3) @(posedge i_mclk);
      stall <= '1;
    end
    // Fill until refused, drain with and without the inter-byte gap
    sink.got.delete();
    sink.at.delete();
    for (int g = 0; g < 2; g++) begin
      wr(SWD_OFS_FRAME, g ? 8'h80 : 8'h06);
      i_multi_load <= '1;
      push(order[2 * g]);
      push(order[2 * g + 1]);
      @(negedge i_mclk);
      chk(8'(o_tx_ready), 8'h00);
      @(posedge i_mclk);
      stall <= '0;
      repeat (8) @(posedge i_mclk);
      stall <= '1;
    end
    @(negedge i_mclk);
    chk(8'(sink.got.size()), 8'h04);
    foreach (order[i]) chk(sink.got[i], order[i]);
    chk(8'(sink.at[1] - sink.at[0]), 8'h01);
    chk(8'(sink.at[3] - sink.at[2]), 8'h03);
    // Access layer silent: time-out
    @(posedge i_mclk);
    i_acc_request <= '1;
    @(posedge i_mclk);
    i_acc_request <= '0;
    n = 0;
    while (o_timeout !== 1'b1 && n < 70000) begin
      @(posedge i_mclk);
      n++;
    end
    chk(8'(n > 65533 && n < 65537), 8'h01);
    rd(SWD_OFS_ERR);
    chk(rv, 8'h03);
    // System reset during a load, with and without the negative ack
    @(posedge i_mclk);
    i_ldst_active <= '1;
    wr(SWD_OFS_RST, 8'h59);
    chk({6'h00, o_sys_reset, o_link_enable}, 8'h03);
    chk(8'(o_nack_send), 8'h01);
    wr(SWD_OFS_DIS, 8'h10);
    chk(8'(o_nack_send), 8'h00);
    wr(SWD_OFS_RST, 8'h00);
    chk(8'(o_sys_reset), 8'h00);
    // System asleep with its clock stopped, clock request off then on
    wr(SWD_OFS_SYSCTL, 8'h00);
    @(posedge i_mclk);
    i_sys_asleep_pin <= '1;
    i_sys_clk_running_pin <= '0;
    repeat (4) @(posedge i_mclk);
    rd(SWD_OFS_SYSSTAT);
    chk(8'(rv[4]), 8'h01);
    chk(8'(o_sys_bus_allowed), 8'h00);
    wr(SWD_OFS_SYSCTL, 8'h01);
    chk(8'(o_sys_bus_allowed), 8'h01);
    @(posedge i_mclk);
    i_sys_clk_running_pin <= '1;
    i_key_erase <= '1;
    @(posedge i_mclk);
    i_key_erase <= '0;
    rd(SWD_OFS_KEY);
    chk(rv & 8'h08, 8'h08);
    wr(SWD_OFS_RST, 8'h59);
    wr(SWD_OFS_RST, 8'h00);
    rd(SWD_OFS_KEY);
    chk(rv & 8'h08, 8'h00);
    // Port disable
    wr(SWD_OFS_DIS, 8'h04);
    chk({6'h00, o_link_enable, o_sys_clock_request}, 8'h00);
    chk(8'(o_parity_check_on), 8'h01);
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    chk(8'(o_link_enable), 8'h00);
    close_out();
  end
endmodule : tb
